// ### core/pad_function_select.sv
/*
 * Pad function select: one software control word that routes shared
 * pads between GPIO, PWM, trace and serial/CAN/pulse-mod functions.
 * Assumes a plain register port on clock_in; function sources come
 * from logic on the same clock, so nothing here is synchronised.
 */
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps

module pad_function_select
#(
  parameter bit FAST_IMPL = 1'b0,
  parameter int CS_COUNT = 4
)
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [31:0] reg_rdata_out,
  // Debug trace port state and data
  input wire logic trace_full_port_in,
  input wire pfs_pkg::pfs_pad_t trace_bit6_in,
  // Function sources, indexed by pad
  input wire pfs_pkg::pfs_pad_t [pfs_pkg::PFS_NUM_PADS-1:0] gpio_src_in,
  input wire pfs_pkg::pfs_pad_t [pfs_pkg::PFS_NUM_PADS-1:0] pwm_src_in,
  // Shared pads
  output pfs_pkg::pfs_pad_t [pfs_pkg::PFS_NUM_PADS-1:0] pad_out,
  // Chip selects
  input wire logic cs_expanded_mode_in,
  input wire logic [CS_COUNT-1:0] cs_assert_in,
  output logic [CS_COUNT-1:0] cs_level_out,
  // Pad configuration levels
  output logic bus_predischarge_enable_out,
  output logic [1:0] can_serial_pad_route_out,
  output logic [2:0] pulse_mod_pad_route_out,
  output logic pulse_mod_pad_voltage_out
);
  import pfs_pkg::*;

  // ****************************************************************
  // Control register
  // ****************************************************************
  localparam logic [31:0] PREDIS_BIT = PFS_BIT << PFS_POS_PREDISCHARGE;
  // The predischarge bit is reserved in the fast implementation
  localparam logic [31:0] EFFECTIVE_MASK =
    FAST_IMPL ? (PFS_WRITE_MASK & ~PREDIS_BIT) : PFS_WRITE_MASK;

  logic [31:0] ctrl_q;
  logic [31:0] rdata_q;
  logic hit;

  assign hit = (reg_addr_in == PFS_ADDR_PAD_CTRL2);

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ctrl_q <= PFS_PAD_CTRL2_RESET;
    end
    else if (reg_write_in && hit)
    begin
      ctrl_q <= reg_wdata_in & EFFECTIVE_MASK;
    end
  end

  // Read data stand for exactly one cycle after the strobe
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else if (reg_read_in && hit)
    begin
      rdata_q <= ctrl_q & EFFECTIVE_MASK;
    end
    else
    begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign reg_rdata_out = rdata_q;

  // ****************************************************************
  // Field decode
  // ****************************************************************
  logic trace_sel;
  logic pwm4_sel;
  logic trace_on_primary;
  logic trace_on_alternate;

  assign trace_sel = ctrl_q[PFS_POS_TRACE_SEL];
  assign pwm4_sel = ctrl_q[PFS_POS_PWM4_SEL];
  assign trace_on_primary = trace_full_port_in && !trace_sel;
  assign trace_on_alternate = trace_full_port_in && trace_sel;

  assign bus_predischarge_enable_out = ctrl_q[PFS_POS_PREDISCHARGE];
  assign can_serial_pad_route_out =
    ctrl_q[PFS_POS_CAN_ROUTE_HI:PFS_POS_CAN_ROUTE_LO];
  assign pulse_mod_pad_route_out =
    ctrl_q[PFS_POS_PM_ROUTE_HI:PFS_POS_PM_ROUTE_LO];
  assign pulse_mod_pad_voltage_out = ctrl_q[PFS_POS_PM_VOLTAGE];

  // ****************************************************************
  // Pad function per pad
  // ****************************************************************
  pfs_pad_fn_t pad_fn [PFS_NUM_PADS];

  always_comb
  begin
    pad_fn[PFS_PAD_PWM5] = ctrl_q[PFS_POS_PWM5_SEL] ? PFS_FN_PWM : PFS_FN_GPIO;
    pad_fn[PFS_PAD_PWM20] = ctrl_q[PFS_POS_PWM20_SEL] ? PFS_FN_PWM : PFS_FN_GPIO;
    pad_fn[PFS_PAD_PWM21] = ctrl_q[PFS_POS_PWM21_SEL] ? PFS_FN_PWM : PFS_FN_GPIO;
    // GPIO/PWM4 choice is ignored while trace owns the primary pad
    if (trace_on_primary)
    begin
      pad_fn[PFS_PAD_PRIMARY] = PFS_FN_TRACE;
    end
    else
    begin
      pad_fn[PFS_PAD_PRIMARY] = pwm4_sel ? PFS_FN_PWM : PFS_FN_GPIO;
    end
    // Alternate pad has no GPIO; it is PWM18 unless trace moves there
    pad_fn[PFS_PAD_ALTERNATE] = trace_on_alternate ? PFS_FN_TRACE : PFS_FN_PWM;
  end

  genvar gi;
  generate
    for (gi = 0; gi < PFS_NUM_PADS; gi++)
    begin : g_pad
      pfs_pad_mux u_mux
      (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .gpio_in(gpio_src_in[gi]),
        .pwm_in(pwm_src_in[gi]),
        .trace_in(trace_bit6_in),
        .fn_in(pad_fn[gi]),
        .pad_out(pad_out[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Chip-select polarity
  // ****************************************************************
  logic [CS_COUNT-1:0] cs_q;

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cs_q <= '0;
    end
    else if (cs_expanded_mode_in && ctrl_q[PFS_POS_CS_POLARITY])
    begin
      cs_q <= ~cs_assert_in;
    end
    else
    begin
      cs_q <= cs_assert_in;
    end
  end

  assign cs_level_out = cs_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_reserved_zero;
    @(posedge clock_in) disable iff (rst_in)
      (ctrl_q & ~EFFECTIVE_MASK) == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved control bit set");

  property p_write_lands;
    @(posedge clock_in) disable iff (rst_in)
      (reg_write_in && hit) |=> (ctrl_q == ($past(reg_wdata_in) & EFFECTIVE_MASK));
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("write did not land in control word");

  property p_read_back;
    @(posedge clock_in) disable iff (rst_in)
      (reg_read_in && hit) |=> (reg_rdata_out == $past(ctrl_q)) ##1
        (reg_rdata_out == 32'h0000_0000 || $past(reg_read_in));
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("read data wrong or held too long");

  property p_predischarge;
    @(posedge clock_in) disable iff (rst_in)
      (reg_write_in && hit && !FAST_IMPL) |=>
        (bus_predischarge_enable_out == $past(reg_wdata_in[31]));
  endproperty
  a_predischarge: assert property (p_predischarge)
    else $error("predischarge enable does not follow word MSB");

  property p_pwm5_pad;
    @(posedge clock_in) disable iff (rst_in)
      ctrl_q[PFS_POS_PWM5_SEL] |=> (pad_out[PFS_PAD_PWM5] == $past(pwm_src_in[PFS_PAD_PWM5]));
  endproperty
  a_pwm5_pad: assert property (p_pwm5_pad)
    else $error("pwm5 pad not carrying pwm5");

  property p_gpio_pwm5_pad;
    @(posedge clock_in) disable iff (rst_in)
      !ctrl_q[PFS_POS_PWM5_SEL] |=>
        (pad_out[PFS_PAD_PWM5] == $past(gpio_src_in[PFS_PAD_PWM5]));
  endproperty
  a_gpio_pwm5_pad: assert property (p_gpio_pwm5_pad)
    else $error("pwm5 pad not carrying gpio");

  property p_pwm20_pad;
    @(posedge clock_in) disable iff (rst_in)
      ctrl_q[PFS_POS_PWM20_SEL] |=>
        (pad_out[PFS_PAD_PWM20] == $past(pwm_src_in[PFS_PAD_PWM20]));
  endproperty
  a_pwm20_pad: assert property (p_pwm20_pad)
    else $error("pwm20 pad not carrying pwm20");

  property p_pwm21_pad;
    @(posedge clock_in) disable iff (rst_in)
      ctrl_q[PFS_POS_PWM21_SEL] |=>
        (pad_out[PFS_PAD_PWM21] == $past(pwm_src_in[PFS_PAD_PWM21]));
  endproperty
  a_pwm21_pad: assert property (p_pwm21_pad)
    else $error("pwm21 pad not carrying pwm21");

  property p_can_route;
    @(posedge clock_in) disable iff (rst_in)
      (reg_write_in && hit) |=>
        (can_serial_pad_route_out == $past(reg_wdata_in[27:26]));
  endproperty
  a_can_route: assert property (p_can_route)
    else $error("serial/CAN route field misplaced");

  property p_cs_pass;
    @(posedge clock_in) disable iff (rst_in)
      !(cs_expanded_mode_in && ctrl_q[PFS_POS_CS_POLARITY]) |=>
        (cs_level_out == $past(cs_assert_in));
  endproperty
  a_cs_pass: assert property (p_cs_pass)
    else $error("chip select not passed through active high");

  property p_trace_primary;
    @(posedge clock_in) disable iff (rst_in)
      (trace_full_port_in && !trace_sel) |=>
        (pad_out[PFS_PAD_PRIMARY] == $past(trace_bit6_in)) &&
        (pad_out[PFS_PAD_ALTERNATE] == $past(pwm_src_in[PFS_PAD_ALTERNATE]));
  endproperty
  a_trace_primary: assert property (p_trace_primary)
    else $error("trace not on primary pad");

  property p_trace_alternate;
    @(posedge clock_in) disable iff (rst_in)
      (trace_full_port_in && trace_sel && !pwm4_sel) |=>
        (pad_out[PFS_PAD_ALTERNATE] == $past(trace_bit6_in)) &&
        (pad_out[PFS_PAD_PRIMARY] == $past(gpio_src_in[PFS_PAD_PRIMARY]));
  endproperty
  a_trace_alternate: assert property (p_trace_alternate)
    else $error("trace not on alternate pad");

  property p_no_full_port;
    @(posedge clock_in) disable iff (rst_in)
      (!trace_full_port_in && pwm4_sel) |=>
        (pad_out[PFS_PAD_ALTERNATE] == $past(pwm_src_in[PFS_PAD_ALTERNATE])) &&
        (pad_out[PFS_PAD_PRIMARY] == $past(pwm_src_in[PFS_PAD_PRIMARY]));
  endproperty
  a_no_full_port: assert property (p_no_full_port)
    else $error("pads wrong outside full port mode");

  property p_reset_trace;
    @(posedge clock_in) disable iff (rst_in)
      $past(rst_in) |-> !trace_sel;
  endproperty
  a_reset_trace: assert property (p_reset_trace)
    else $error("trace select not clear after reset");

  property p_cs_polarity;
    @(posedge clock_in) disable iff (rst_in)
      (cs_expanded_mode_in && ctrl_q[PFS_POS_CS_POLARITY]) |=>
        (cs_level_out == ~$past(cs_assert_in));
  endproperty
  a_cs_polarity: assert property (p_cs_polarity)
    else $error("chip select not inverted");

  property p_voltage;
    @(posedge clock_in) disable iff (rst_in)
      pulse_mod_pad_voltage_out == ctrl_q[15] && pulse_mod_pad_route_out == ctrl_q[20:18];
  endproperty
  a_voltage: assert property (p_voltage)
    else $error("pulse-mod fields misplaced");

endmodule

// ### core/pfs_pkg.sv
/*
 * Package for the pad function select block: register map, field
 * positions, reset value and the pad carrier types.
 * Assumes a single 32-bit control word on a plain register port.
 */
package pfs_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] PFS_ADDR_PAD_CTRL2 = 8'h00;
  localparam logic [31:0] PFS_PAD_CTRL2_RESET = 32'h0000_0000;

  // ****************************************************************
  // Field positions, big-endian: field bit n sits at word bit 31-n
  // ****************************************************************
  localparam int PFS_POS_PREDISCHARGE = 31 - 0;
  localparam int PFS_POS_CAN_ROUTE_HI = 31 - 4;
  localparam int PFS_POS_CAN_ROUTE_LO = 31 - 5;
  localparam int PFS_POS_PWM5_SEL = 31 - 6;
  localparam int PFS_POS_PWM20_SEL = 31 - 7;
  localparam int PFS_POS_PWM21_SEL = 31 - 8;
  localparam int PFS_POS_PM_ROUTE_HI = 31 - 11;
  localparam int PFS_POS_PM_ROUTE_LO = 31 - 13;
  localparam int PFS_POS_PM_VOLTAGE = 31 - 16;
  localparam int PFS_POS_TRACE_SEL = 31 - 20;
  localparam int PFS_POS_PWM4_SEL = 31 - 21;
  localparam int PFS_POS_CS_POLARITY = 31 - 25;

  localparam logic [31:0] PFS_BIT = 32'h0000_0001;
  localparam logic [31:0] PFS_WRITE_MASK =
    (PFS_BIT << PFS_POS_PREDISCHARGE) |
    (PFS_BIT << PFS_POS_CAN_ROUTE_HI) | (PFS_BIT << PFS_POS_CAN_ROUTE_LO) |
    (PFS_BIT << PFS_POS_PWM5_SEL) | (PFS_BIT << PFS_POS_PWM20_SEL) |
    (PFS_BIT << PFS_POS_PWM21_SEL) |
    (PFS_BIT << PFS_POS_PM_ROUTE_HI) | (PFS_BIT << (PFS_POS_PM_ROUTE_HI - 1)) |
    (PFS_BIT << PFS_POS_PM_ROUTE_LO) |
    (PFS_BIT << PFS_POS_PM_VOLTAGE) | (PFS_BIT << PFS_POS_TRACE_SEL) |
    (PFS_BIT << PFS_POS_PWM4_SEL) | (PFS_BIT << PFS_POS_CS_POLARITY);

  // ****************************************************************
  // Pads
  // ****************************************************************
  localparam int PFS_NUM_PADS = 5;
  localparam int PFS_PAD_PWM5 = 0;
  localparam int PFS_PAD_PWM20 = 1;
  localparam int PFS_PAD_PWM21 = 2;
  localparam int PFS_PAD_PRIMARY = 3;
  localparam int PFS_PAD_ALTERNATE = 4;

  typedef enum logic [1:0] {
    PFS_FN_GPIO = 2'b00,
    PFS_FN_PWM = 2'b01,
    PFS_FN_TRACE = 2'b10
  } pfs_pad_fn_t;

  typedef struct packed {
    logic drive;
    logic oe;
  } pfs_pad_t;

endpackage

// ### core/pfs_pad_mux.sv
/*
 * One shared output pad: picks one of three function sources and
 * registers the result so the pad sees no mux glitches.
 * Assumes all sources and the select are on clock_in.
 */
`timescale 1ns/1ps

module pfs_pad_mux
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Function sources
  input wire pfs_pkg::pfs_pad_t gpio_in,
  input wire pfs_pkg::pfs_pad_t pwm_in,
  input wire pfs_pkg::pfs_pad_t trace_in,
  input wire pfs_pkg::pfs_pad_fn_t fn_in,
  // Pad side
  output pfs_pkg::pfs_pad_t pad_out
);
  import pfs_pkg::*;

  pfs_pad_t pad_d;
  pfs_pad_t pad_q;

  always_comb
  begin
    case (fn_in)
      PFS_FN_GPIO: pad_d = gpio_in;
      PFS_FN_PWM: pad_d = pwm_in;
      PFS_FN_TRACE: pad_d = trace_in;
      default: pad_d = '0;
    endcase
  end

  // Pad released (not driven) while in reset
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pad_q <= '0;
    end
    else
    begin
      pad_q <= pad_d;
    end
  end

  assign pad_out = pad_q;

endmodule

// ### test/pad_function_select_bench.sv
/*
 * Self-checking bench for pad_function_select: register port, pad
 * routing, chip-select polarity and config levels, random plus corners.
 * Assumes pfs_pkg is compiled first; design assertions live inline.
 */
`timescale 1ns/1ps

module pad_function_select_bench;
  import pfs_pkg::*;

  localparam int CSN = 4;
  // Word bits that hold a field, bit n at word bit 31-n
  localparam logic [31:0] WMASK = 32'h8F9C_8C40;

  logic clock_in;
  logic rst_in;
  logic [7:0] reg_addr_in;
  logic [31:0] reg_wdata_in;
  logic reg_write_in;
  logic reg_read_in;
  logic [31:0] reg_rdata_out;
  logic trace_full_port_in;
  pfs_pad_t trace_bit6_in;
  pfs_pad_t [PFS_NUM_PADS-1:0] gpio_src_in;
  pfs_pad_t [PFS_NUM_PADS-1:0] pwm_src_in;
  pfs_pad_t [PFS_NUM_PADS-1:0] pad_out;
  logic cs_expanded_mode_in;
  logic [CSN-1:0] cs_assert_in;
  logic [CSN-1:0] cs_level_out;
  logic bus_predischarge_enable_out;
  logic [1:0] can_serial_pad_route_out;
  logic [2:0] pulse_mod_pad_route_out;
  logic pulse_mod_pad_voltage_out;
  int err_count = 0;
  int num_checks = 0;
  logic [31:0] w;

  pad_function_select #(.FAST_IMPL(1'b0), .CS_COUNT(CSN)) dut_u (
    .clock_in(clock_in), .rst_in(rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out),
    .trace_full_port_in(trace_full_port_in), .trace_bit6_in(trace_bit6_in),
    .gpio_src_in(gpio_src_in), .pwm_src_in(pwm_src_in), .pad_out(pad_out),
    .cs_expanded_mode_in(cs_expanded_mode_in), .cs_assert_in(cs_assert_in),
    .cs_level_out(cs_level_out),
    .bus_predischarge_enable_out(bus_predischarge_enable_out),
    .can_serial_pad_route_out(can_serial_pad_route_out),
    .pulse_mod_pad_route_out(pulse_mod_pad_route_out),
    .pulse_mod_pad_voltage_out(pulse_mod_pad_voltage_out)
  );

  initial
  begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end

  // ****************************************************************
  // Checking and closing
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Expected pad word from control word and the current sources
  function automatic logic [9:0] exp_pads(input logic [31:0] cw);
    pfs_pad_t [PFS_NUM_PADS-1:0] p;
    for (int k = 0; k < 3; k++)
      p[k] = cw[25-k] ? pwm_src_in[k] : gpio_src_in[k];
    if (trace_full_port_in && !cw[31-20])
      p[3] = trace_bit6_in;
    else
      p[3] = cw[31-21] ? pwm_src_in[3] : gpio_src_in[3];
    p[4] = (trace_full_port_in && cw[31-20]) ? trace_bit6_in : pwm_src_in[4];
    return p;
  endfunction

  function automatic logic [CSN-1:0] exp_cs(input logic [31:0] cw);
    return (cs_expanded_mode_in && cw[31-25]) ? ~cs_assert_in : cs_assert_in;
  endfunction

  // ****************************************************************
  // Register bus cycles
  // ****************************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge clock_in);
    reg_write_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge clock_in);
    reg_read_in <= 1'b0;
    #1;
    check(reg_rdata_out, exp);
  endtask

  task automatic randomize_sources();
    gpio_src_in <= 10'($urandom);
    pwm_src_in <= 10'($urandom);
    trace_bit6_in <= 2'($urandom);
    trace_full_port_in <= 1'($urandom);
    cs_expanded_mode_in <= 1'($urandom);
    cs_assert_in <= CSN'($urandom);
  endtask

  initial
  begin
    repeat (5000) @(posedge clock_in);
    err_count++;
    report_and_stop();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    void'($urandom(32'he2ed612c));
    rst_in = 1'b1;
    reg_addr_in = 8'h00;
    reg_wdata_in = 32'h0000_0000;
    reg_write_in = 1'b0;
    reg_read_in = 1'b0;
    trace_full_port_in = 1'b1;
    trace_bit6_in = 2'b11;
    gpio_src_in = '0;
    pwm_src_in = '0;
    cs_expanded_mode_in = 1'b0;
    cs_assert_in = '0;
    repeat (20) @(posedge clock_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    #1;
    check(pad_out[PFS_PAD_PRIMARY], 2'b11);
    rd(8'h00, PFS_PAD_CTRL2_RESET);
    // Unmapped place: write dropped, read zero
    wr(8'h5a, 32'hFFFF_FFFF);
    rd(8'h5a, 32'h0000_0000);
    rd(8'h00, PFS_PAD_CTRL2_RESET);
    // Write, one idle cycle, then read, then data drops back to zero
    wr(8'h00, 32'hFFFF_FFFF);
    rd(8'h00, WMASK);
    @(posedge clock_in);
    #1;
    check(reg_rdata_out, 32'h0000_0000);
    for (int i = 0; i < 40; i++)
    begin
      case (i)
        0: w = 32'h0000_0000;
        1: w = 32'hFFFF_FFFF;
        2: w = 32'h0000_0800;
        3: w = 32'h0000_0400;
        4: w = 32'h0000_0040;
        default: w = $urandom;
      endcase
      wr(8'h00, w);
      randomize_sources();
      @(posedge clock_in);
      #1;
      check(pad_out, exp_pads(w));
      check(cs_level_out, exp_cs(w));
      check({bus_predischarge_enable_out, can_serial_pad_route_out,
             pulse_mod_pad_route_out, pulse_mod_pad_voltage_out},
            {w[31], w[27:26], w[20:18], w[15]});
      rd(8'h00, w & WMASK);
    end
    // Reset in mid-run brings back the reset word and trace routing
    @(posedge clock_in);
    rst_in <= 1'b1;
    trace_full_port_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    #1;
    check(pad_out[PFS_PAD_PRIMARY], trace_bit6_in);
    check(bus_predischarge_enable_out, 1'b0);
    rd(8'h00, PFS_PAD_CTRL2_RESET);
    report_and_stop();
  end

endmodule
